// ### verilog/vci_cfg.svh
// Purpose: constants for the voiceband codec interface logic
// Assumes: word-addressed data memory bus, 16-bit data
// Notes: 14-bit addresses are data memory word addresses, 8-bit ones Avalon byte addresses
`ifndef VCI_CFG_SVH
`define VCI_CFG_SVH
`define VCI_ADDR_CTRL 14'h3FEE
`define VCI_ADDR_RX 14'h3FED
`define VCI_ADDR_TX 14'h3FEC
`define VCI_ADDR_STAT 14'h3FE0
`define VCI_ADDR_ABUF 14'h3FE1
`define VCI_ADDR_HCMD 8'h00
`define VCI_ADDR_HSTAT 8'h04
`define VCI_ADDR_HRX 8'h08
`define VCI_ADDR_HTX 8'h0C
`define VCI_ADDR_HABUF 8'h10
`define VCI_ADDR_HCNT 8'h14
`define VCI_CTRL_RESET 16'h0000
`define VCI_CTRL_MASK 16'h077D
`define VCI_BIT_GAIN_LO 0
`define VCI_BIT_AUX_SEL 8
`define VCI_BIT_GAIN_HI 9
`define VCI_BIT_OFFSET 10
`define VCI_BIT_DAC_LSB 2
`define VCI_BIT_PWR_A 5
`define VCI_BIT_PWR_B 6
`define VCI_ABUF_RX 0
`define VCI_ABUF_TX 1
`define VCI_ABUF_LEN_LSB 8
`define VCI_SYS_CLK_KHZ 250000
`define VCI_SAMPLE_KHZ 8
`define VCI_INSTR_PER_SAMPLE 3250
`endif

// ### verilog/vci_pkg.sv
// Purpose: shared types for the codec interface
// Assumes: nothing
// Notes: constants live in vci_cfg.svh
package vci_pkg;
  typedef enum logic [1:0] {VCI_H_IDLE, VCI_H_REQ, VCI_H_DONE} vci_hstate_t;
  typedef enum logic [1:0] {VCI_D_IDLE, VCI_D_RACK} vci_dstate_t;
endpackage

// ### verilog/vci_if.sv
// Purpose: data memory bus between processor core and codec logic
// Assumes: single clock, one access per request
// Notes: ack answers each request for one cycle
`timescale 1ns/1ps
interface vci_if;
  logic req; // Access request, level
  logic wr; // 1 write, 0 read
  logic [13:0] addr; // Data memory word address
  logic [15:0] wdata; // Write data
  logic [15:0] rdata; // Read data
  logic ack; // One-cycle completion
  logic rx_irq; // ADC receive interrupt pulse
  logic tx_irq; // DAC transmit interrupt pulse
  modport dev (input req, wr, addr, wdata, output rdata, ack, rx_irq, tx_irq);
  modport host (output req, wr, addr, wdata, input rdata, ack, rx_irq, tx_irq);
endinterface

// ### verilog/vci_codec_dev.sv
// Purpose: codec control, data registers, sample timing, autobuffer
// Assumes: sys_clk at 250 MHz; rates scaled to 8 kHz
// Notes: analog side reached through plain ports
// Functional notes
// - control register at 0x3FEE
// - software writes zero to unused bits
// - select primary or auxiliary ADC input
// - two-bit ADC gain at bits 9,0
// - bit 10 adds ADC offset
// - offset use requires high-pass filter enabled
// - three-bit DAC gain at bits 2-4
// - receive and transmit sample data registers
// - optional automatic block transfers
// - one sample each way per 125 us
// - two converter interrupt sources
// - receive interrupt when ADC sample ready
// - transmit interrupt when DAC ready
// - autobuffer interrupts once per block
// - both interrupts in same cycle, except when only one abuf_en bit is set
// - interrupts start when both power bits set
// - without autobuffer unmask only one interrupt
// - with autobuffer unmask both interrupts
// - registers reached as data memory addresses
// - receive register at 0x3FED
// - transmit register at 0x3FEC
`timescale 1ns/1ps
`include "vci_cfg.svh"
module vci_codec_dev #(
  parameter int SAMPLE_CYCLES =
    `VCI_SYS_CLK_KHZ / `VCI_SAMPLE_KHZ, // Sample period in clocks
  parameter int BLK_W = 8 // Block length width
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Sync reset, high
  vci_if.dev bus, // Data memory side
  input wire logic [15:0] adc_sample, // Converted ADC word
  output logic [15:0] dac_sample, // Word to DAC modulator
  output logic dac_strobe, // DAC word taken, pulse
  output logic adc_aux_sel, // 1 auxiliary input
  output logic [1:0] adc_gain, // ADC gain code
  output logic adc_offset_en, // ADC offset on
  output logic [2:0] dac_gain, // DAC gain code
  output logic codec_power_up // Codec powered
);
  localparam int CW = $clog2(SAMPLE_CYCLES);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] dac;
    logic [CW-1:0] tick;
    logic [BLK_W-1:0] rx_cnt;
    logic [BLK_W-1:0] tx_cnt;
    logic [1:0] abuf_en;
    logic [BLK_W-1:0] blk_len;
    logic rx_irq;
    logic tx_irq;
    logic strobe;
    logic [15:0] rdata;
    logic ack;
  } st_t;

  st_t s_reg;
  st_t s_next;
  logic powered;
  logic sample_evt;

  assign powered = s_reg.ctrl[`VCI_BIT_PWR_A] & s_reg.ctrl[`VCI_BIT_PWR_B];
  assign sample_evt = powered &&
    (s_reg.tick == CW'(SAMPLE_CYCLES - 1));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.rx_irq = 1'b0;
    s_next.tx_irq = 1'b0;
    s_next.strobe = 1'b0;
    // Free-running tick only while powered
    if (!powered) begin
      s_next.tick = '0;
    end else if (sample_evt) begin
      s_next.tick = '0;
    end else begin
      s_next.tick = s_reg.tick + CW'(1);
    end
    if (sample_evt) begin
      s_next.rx = adc_sample;
      s_next.dac = s_reg.tx;
      s_next.strobe = 1'b1;
      // Per-sample or per-block interrupts, each side set by its own abuf_en bit
      if (s_reg.abuf_en[`VCI_ABUF_RX]) begin
        if (s_reg.rx_cnt == s_reg.blk_len) begin
          s_next.rx_cnt = '0;
          s_next.rx_irq = 1'b1;
        end else begin
          s_next.rx_cnt = s_reg.rx_cnt + BLK_W'(1);
        end
      end else begin
        s_next.rx_irq = 1'b1;
      end
      if (s_reg.abuf_en[`VCI_ABUF_TX]) begin
        if (s_reg.tx_cnt == s_reg.blk_len) begin
          s_next.tx_cnt = '0;
          s_next.tx_irq = 1'b1;
        end else begin
          s_next.tx_cnt = s_reg.tx_cnt + BLK_W'(1);
        end
      end else begin
        s_next.tx_irq = 1'b1;
      end
    end
    if (!powered) begin
      s_next.rx_cnt = '0;
      s_next.tx_cnt = '0;
    end
    // Register access, answered next cycle
    if (bus.req && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.rdata = 16'h0000;
      unique case (bus.addr)
        `VCI_ADDR_CTRL: begin
          if (bus.wr) begin
            s_next.ctrl = bus.wdata & `VCI_CTRL_MASK;
          end else begin
            s_next.rdata = s_reg.ctrl;
          end
        end
        `VCI_ADDR_RX: begin
          if (!bus.wr) begin
            s_next.rdata = s_reg.rx;
          end
        end
        `VCI_ADDR_TX: begin
          if (bus.wr) begin
            s_next.tx = bus.wdata;
          end else begin
            s_next.rdata = s_reg.tx;
          end
        end
        `VCI_ADDR_ABUF: begin
          if (bus.wr) begin
            s_next.abuf_en = bus.wdata[1:0];
            s_next.blk_len = bus.wdata[`VCI_ABUF_LEN_LSB +: BLK_W];
            s_next.rx_cnt = '0;
            s_next.tx_cnt = '0;
          end else begin
            s_next.rdata = {bus.wdata[15:0] & 16'h0000}
              | 16'(s_reg.abuf_en)
              | (16'(s_reg.blk_len) << `VCI_ABUF_LEN_LSB);
          end
        end
        `VCI_ADDR_STAT: begin
          if (!bus.wr) begin
            s_next.rdata = 16'(s_reg.rx_cnt) | 16'(powered) << 15;
          end
        end
        default: begin
          s_next.rdata = 16'h0000; // Unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.rdata = s_reg.rdata;
  assign bus.ack = s_reg.ack;
  assign bus.rx_irq = s_reg.rx_irq;
  assign bus.tx_irq = s_reg.tx_irq;
  assign dac_sample = s_reg.dac;
  assign dac_strobe = s_reg.strobe;
  assign adc_aux_sel = ~s_reg.ctrl[`VCI_BIT_AUX_SEL];
  assign adc_gain = {s_reg.ctrl[`VCI_BIT_GAIN_HI],
    s_reg.ctrl[`VCI_BIT_GAIN_LO]};
  assign adc_offset_en = s_reg.ctrl[`VCI_BIT_OFFSET];
  assign dac_gain = s_reg.ctrl[`VCI_BIT_DAC_LSB +: 3];
  assign codec_power_up = powered;

endmodule // vci_codec_dev

// ### verilog/vci_codec_host.sv
// Purpose: processor-side master driven by Avalon-MM commands
// Assumes: one command at a time
// Notes: codec bus accesses are forwarded one to one
`timescale 1ns/1ps
`include "vci_cfg.svh"
module vci_codec_host (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Sync reset, high
  vci_if.host bus, // Toward codec logic
  input wire logic [7:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon stall
  input wire logic [1:0] interrupt_mask_word // Unmask rx, tx
);
  typedef struct packed {
    vci_pkg::vci_hstate_t st;
    logic req;
    logic wr;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic [31:0] rdata;
    logic rx_pend;
    logic tx_pend;
  } hs_t;

  hs_t h_reg;
  hs_t h_next;

  // ----------------------------------------
  // Command decode and bus sequencing
  // ----------------------------------------
  always_comb begin
    h_next = h_reg;
    // Pending flags: set wins over clear
    if (bus.rx_irq && interrupt_mask_word[0]) begin
      h_next.rx_pend = 1'b1;
    end
    if (bus.tx_irq && interrupt_mask_word[1]) begin
      h_next.tx_pend = 1'b1;
    end
    unique case (h_reg.st)
      vci_pkg::VCI_H_IDLE: begin
        if (avs_write || avs_read) begin
          h_next.rdata = 32'h00000000;
          h_next.st = vci_pkg::VCI_H_DONE;
          unique case (avs_address)
            `VCI_ADDR_HRX: begin
              h_next.req = 1'b1;
              h_next.wr = 1'b0;
              h_next.addr = `VCI_ADDR_RX;
              h_next.st = vci_pkg::VCI_H_REQ;
            end
            `VCI_ADDR_HTX, `VCI_ADDR_HCMD: begin
              h_next.req = 1'b1;
              h_next.wr = avs_write;
              h_next.addr = (avs_address == `VCI_ADDR_HTX) ?
                `VCI_ADDR_TX : `VCI_ADDR_CTRL;
              h_next.wdata = avs_writedata[15:0] & ((avs_address ==
                `VCI_ADDR_HCMD) ? `VCI_CTRL_MASK : 16'hFFFF);
              h_next.st = vci_pkg::VCI_H_REQ;
            end
            // Block setup and sample count, else unreachable by software
            `VCI_ADDR_HABUF, `VCI_ADDR_HCNT: begin
              h_next.req = 1'b1;
              h_next.wr = avs_write;
              h_next.addr = (avs_address == `VCI_ADDR_HABUF) ?
                `VCI_ADDR_ABUF : `VCI_ADDR_STAT;
              h_next.wdata = avs_writedata[15:0];
              h_next.st = vci_pkg::VCI_H_REQ;
            end
            `VCI_ADDR_HSTAT: begin
              h_next.rdata = {30'h00000000, h_reg.tx_pend, h_reg.rx_pend};
              if (avs_write) begin
                if (avs_writedata[0] && !bus.rx_irq) h_next.rx_pend = 1'b0;
                if (avs_writedata[1] && !bus.tx_irq) h_next.tx_pend = 1'b0;
              end
            end
            default: begin
              h_next.rdata = 32'h00000000;
            end
          endcase
        end
      end
      vci_pkg::VCI_H_REQ: begin
        if (bus.ack) begin
          h_next.req = 1'b0;
          h_next.rdata = {16'h0000, bus.rdata};
          h_next.st = vci_pkg::VCI_H_DONE;
        end
      end
      vci_pkg::VCI_H_DONE: begin
        h_next.st = vci_pkg::VCI_H_IDLE;
      end
      default: begin
        h_next.st = vci_pkg::VCI_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  assign bus.req = h_reg.req;
  assign bus.wr = h_reg.wr;
  assign bus.addr = h_reg.addr;
  assign bus.wdata = h_reg.wdata;
  assign avs_readdata = h_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) &&
    (h_reg.st != vci_pkg::VCI_H_DONE);

endmodule // vci_codec_host

// ### dv/vci_bus_chk.sv
// Purpose: checks on the codec data memory bus
// Assumes: one clock, sync reset high
// Notes: power state follows control writes
`timescale 1ns/1ps
`include "vci_cfg.svh"
module vci_bus_chk #(
  parameter int SAMPLE_CYCLES = 31250 // Sample period, clocks
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Sync reset, high
  input wire logic req, // Request
  input wire logic wr, // Write
  input wire logic [13:0] addr, // Word address
  input wire logic [15:0] wdata, // Write data
  input wire logic [15:0] rdata, // Read data
  input wire logic ack, // Completion pulse
  input wire logic rx_irq, // Receive irq
  input wire logic tx_irq // Transmit irq
);
  // ----
  // Shadow
  // ----
  typedef struct packed {
    logic pwr;
    logic seen;
    logic fresh;
    logic blk;
    logic [7:0] len;
    logic [15:0] ctrl;
    logic [31:0] gap;
  } vci_chk_t;
  vci_chk_t st_reg;
  vci_chk_t st_next;
  always_comb begin
    st_next = st_reg;
    if (ack && wr && addr == `VCI_ADDR_CTRL) begin
      st_next.ctrl = wdata & `VCI_CTRL_MASK;
      st_next.pwr = wdata[`VCI_BIT_PWR_A] & wdata[`VCI_BIT_PWR_B];
    end
    if (!st_reg.pwr) begin
      st_next.seen = 1'b0;
      st_next.fresh = 1'b1;
    end else if (rx_irq) begin
      st_next.seen = 1'b1;
      st_next.fresh = 1'b0;
    end
    // Block mode restarts the count, so the next gap is unknown
    if (ack && wr && addr == `VCI_ADDR_ABUF) begin
      st_next.blk = wdata[`VCI_ABUF_RX];
      st_next.len = wdata[`VCI_ABUF_LEN_LSB +: 8];
      st_next.seen = 1'b0;
      st_next.fresh = 1'b0;
    end
    // Shadow power lags one cycle, so first gap is loose
    st_next.gap = (!st_reg.pwr || rx_irq) ? 32'h1 : st_reg.gap + 32'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) st_reg <= '0;
    else st_reg <= st_next;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (req && !ack |=> ack)
    else $error("request not answered");
  ctrl_read_a: assert property (ack && !wr && addr == `VCI_ADDR_CTRL
    |-> rdata == st_reg.ctrl) else $error("control readback");
  irq_pair_a: assert property (rx_irq == tx_irq)
    else $error("irqs not together");
  irq_pulse_a: assert property (rx_irq |=> !rx_irq [*8])
    else $error("irq too long");
  irq_power_a: assert property (rx_irq |-> st_reg.pwr)
    else $error("irq while powered down");
  irq_period_a: assert property (rx_irq && st_reg.seen
    |-> st_reg.gap == (st_reg.blk ?
      SAMPLE_CYCLES * (32'(st_reg.len) + 1) : SAMPLE_CYCLES))
    else $error("irq period");
  irq_first_a: assert property (rx_irq && st_reg.fresh
    |-> st_reg.gap inside {[SAMPLE_CYCLES-3:SAMPLE_CYCLES+1]})
    else $error("first irq time");
endmodule // vci_bus_chk

// ### dv/tb.sv
// Purpose: bench for codec host and device ends
// Assumes: 250 MHz clock, short sample period
// Notes: software side over Avalon-MM
`timescale 1ns/1ps
`include "vci_cfg.svh"
module tb;
  localparam int SC = 50;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] adc_sample = 16'h0000;
  logic [15:0] dac_sample;
  logic dac_strobe;
  logic adc_aux_sel;
  logic [1:0] adc_gain;
  logic adc_offset_en;
  logic [2:0] dac_gain;
  logic codec_power_up;
  logic [31:0] q;
  logic [15:0] v;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int irqs = 0;
  int strobes = 0;
  int last_irq = 0;
  int gap = 0;
  int base = 0;
  int sbase = 0;
  logic [1:0] interrupt_mask_word = 2'b01;
  vci_if u_vci_if();
  vci_codec_dev #(.SAMPLE_CYCLES(SC)) u_vci_codec_dev (
    .sys_clk(sys_clk), .rst(rst), .bus(u_vci_if.dev),
    .adc_sample(adc_sample), .dac_sample(dac_sample),
    .dac_strobe(dac_strobe), .adc_aux_sel(adc_aux_sel),
    .adc_gain(adc_gain), .adc_offset_en(adc_offset_en),
    .dac_gain(dac_gain), .codec_power_up(codec_power_up));
  vci_codec_host u_vci_codec_host (
    .sys_clk(sys_clk), .rst(rst), .bus(u_vci_if.host),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .interrupt_mask_word(interrupt_mask_word));
  vci_bus_chk #(.SAMPLE_CYCLES(SC)) u_vci_bus_chk (
    .sys_clk(sys_clk), .rst(rst), .req(u_vci_if.req),
    .wr(u_vci_if.wr), .addr(u_vci_if.addr), .wdata(u_vci_if.wdata),
    .rdata(u_vci_if.rdata), .ack(u_vci_if.ack),
    .rx_irq(u_vci_if.rx_irq), .tx_irq(u_vci_if.tx_irq));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (dac_strobe === 1'b1) strobes++;
    if (u_vci_if.rx_irq === 1'b1) begin
      gap = cycles - last_irq;
      last_irq = cycles;
      irqs++;
    end
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge so back-to-back calls never retoggle in one step
    @(posedge sys_clk);
  endtask
  task automatic wait_irq(input int lim);
    int n0;
    n0 = irqs;
    for (int n = 0; n < lim && irqs == n0; n++) @(posedge sys_clk);
    check(32'(irqs), 32'(n0 + 1));
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, `VCI_ADDR_HCMD, 32'h0);
    check(q, 32'h0);
    check(32'({codec_power_up, adc_gain, dac_gain}), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = 16'((i << 2) | (i & 1) | ((i & 6) << 8) | ((i & 1) << 8));
      xfer(1'b1, `VCI_ADDR_HCMD, {16'h0, v});
      check(32'({adc_gain, dac_gain}), 32'({v[9], v[0], v[4:2]}));
      check(32'({adc_offset_en, adc_aux_sel}), 32'({v[10], !v[8]}));
      xfer(1'b0, `VCI_ADDR_HCMD, 32'h0);
      check(q, {16'h0, v});
    end
    check(32'(irqs), 32'h0);
    $display("test control fields done");
    adc_sample <= 16'hA5C3;
    xfer(1'b1, `VCI_ADDR_HTX, 32'h1234);
    xfer(1'b1, `VCI_ADDR_HCMD, 32'h0060);
    check(32'(codec_power_up), 32'h1);
    wait_irq(SC + 10);
    check(32'(dac_sample), 32'h1234);
    xfer(1'b0, `VCI_ADDR_HRX, 32'h0);
    check(q, 32'hA5C3);
    xfer(1'b0, `VCI_ADDR_HSTAT, 32'h0);
    check(q, 32'h1);
    adc_sample <= 16'h5A3C;
    xfer(1'b0, `VCI_ADDR_HRX, 32'h0);
    check(q, 32'hA5C3);
    wait_irq(SC + 10);
    check(32'(gap), 32'(SC));
    xfer(1'b0, `VCI_ADDR_HRX, 32'h0);
    check(q, 32'h5A3C);
    check(32'(strobes), 32'(irqs));
    $display("test samples done");
    interrupt_mask_word <= 2'b11;
    xfer(1'b1, `VCI_ADDR_HABUF, 32'h0103);
    wait_irq(2 * SC + 10);
    xfer(1'b0, `VCI_ADDR_HCNT, 32'h0);
    check(q, 32'h8000);
    xfer(1'b0, `VCI_ADDR_HSTAT, 32'h0);
    check(q, 32'h3);
    xfer(1'b1, `VCI_ADDR_HSTAT, 32'h3);
    xfer(1'b0, `VCI_ADDR_HSTAT, 32'h0);
    check(q, 32'h0);
    wait_irq(2 * SC + 10);
    check(32'(gap), 32'(2 * SC));
    xfer(1'b1, `VCI_ADDR_HABUF, 32'h0);
    $display("test autobuffer done");
    xfer(1'b1, `VCI_ADDR_HCMD, 32'h0020);
    check(32'(codec_power_up), 32'h0);
    base = irqs;
    sbase = strobes;
    repeat (3 * SC) @(posedge sys_clk);
    check(32'(irqs), 32'(base));
    check(32'(strobes), 32'(sbase));
    xfer(1'b0, `VCI_ADDR_HCNT, 32'h0);
    check(q, 32'h0);
    $display("test power down done");
    print_verdict();
  end
endmodule // tb
